// >>> rtl/ifm_input_mapper.sv
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
// Function
// - Multiplication switch follows terminal 0..7 chosen by its digit, on while ON.
// - Multiplication switch digit 8 holds it off, digit 9 holds it on.
// - Forced-stop input follows its chosen terminal; drive allowed while terminal ON.
// - Forced-stop digit 8 holds it off, 9 on; word resets to 8888.
// - Inversion digit 0 passes, 1 inverts terminals 0 to 3.
module ifm_input_mapper
	import ifm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  termIn,
	output logic             pulseMultSwitch,
	output logic             forcedStopInput,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic        awHeld, next_awHeld;
	logic [7:0]  awAddr, next_awAddr;
	logic        wHeld, next_wHeld;
	logic [31:0] wData, next_wData;
	logic [3:0]  wStrb, next_wStrb;
	logic        next_awReady, next_wReady, next_bValid, next_arReady, next_rValid;
	logic [1:0]  next_bResp, next_rResp;
	logic [31:0] next_rData;
	logic        doWrite;
	logic        applyPulse, next_applyPulse;
	logic [15:0] pulseSel, next_pulseSel;
	logic [15:0] fstopSel, next_fstopSel;
	logic [15:0] invertLow, next_invertLow;
	logic [15:0] activePulse, next_activePulse;
	logic [15:0] activeFstop, next_activeFstop;
	logic [15:0] activeInvert, next_activeInvert;
	logic [7:0]  termCond, next_termCond;
	logic [7:0]  invMask;
	logic        next_pulseMult, next_forcedStop;

	ifm_sel_if pulseBus ();
	ifm_sel_if fstopBus ();

	// ----------------------------------------
	// Byte-lane merge
	// ----------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// ----------------------------------------
	// Bus write path
	// ----------------------------------------
	// Address and data taken in either order, one response after both
	always_comb begin
		next_awHeld = awHeld;
		next_awAddr = awAddr;
		next_wHeld  = wHeld;
		next_wData  = wData;
		next_wStrb  = wStrb;
		next_bValid = s_axi_bvalid;
		next_bResp  = s_axi_bresp;
		doWrite     = awHeld && wHeld && !s_axi_bvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bValid = 1'b0;
		end
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bValid = 1'b1;
			case (awAddr)
				ADDR_PULSE_SEL, ADDR_FSTOP_SEL, ADDR_INVERT_LOW,
				ADDR_CONTROL: next_bResp = RESP_OKAY;
				default:      next_bResp = RESP_SLVERR;
			endcase
		end
		next_awReady = !next_awHeld;
		next_wReady  = !next_wHeld;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld        <= 1'b0;
			awAddr        <= 8'h00;
			wHeld         <= 1'b0;
			wData         <= 32'h00000000;
			wStrb         <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			awHeld        <= next_awHeld;
			awAddr        <= next_awAddr;
			wHeld         <= next_wHeld;
			wData         <= next_wData;
			wStrb         <= next_wStrb;
			s_axi_awready <= next_awReady;
			s_axi_wready  <= next_wReady;
			s_axi_bvalid  <= next_bValid;
			s_axi_bresp   <= next_bResp;
		end
	end

	// ----------------------------------------
	// Setting words, restart and active copies
	// ----------------------------------------
	// Software edits the stored words; the working copies move only on restart
	always_comb begin
		next_pulseSel     = pulseSel;
		next_fstopSel     = fstopSel;
		next_invertLow    = invertLow;
		next_applyPulse   = 1'b0;
		next_activePulse  = activePulse;
		next_activeFstop  = activeFstop;
		next_activeInvert = activeInvert;
		if (doWrite) begin
			case (awAddr)
				ADDR_PULSE_SEL:  next_pulseSel  = merge16(pulseSel, wData, wStrb);
				ADDR_FSTOP_SEL:  next_fstopSel  = merge16(fstopSel, wData, wStrb);
				ADDR_INVERT_LOW: next_invertLow = merge16(invertLow, wData, wStrb);
				ADDR_CONTROL:    next_applyPulse = wStrb[0] && wData[CTRL_RESTART_BIT];
				default:         next_applyPulse = 1'b0;
			endcase
		end
		if (applyPulse) begin
			next_activePulse  = pulseSel;
			next_activeFstop  = fstopSel;
			next_activeInvert = invertLow;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pulseSel     <= RST_PULSE_SEL;
			fstopSel     <= RST_FSTOP_SEL;
			invertLow    <= RST_INVERT_LOW;
			applyPulse   <= 1'b0;
			activePulse  <= RST_PULSE_SEL;
			activeFstop  <= RST_FSTOP_SEL;
			activeInvert <= RST_INVERT_LOW;
		end else begin
			pulseSel     <= next_pulseSel;
			fstopSel     <= next_fstopSel;
			invertLow    <= next_invertLow;
			applyPulse   <= next_applyPulse;
			activePulse  <= next_activePulse;
			activeFstop  <= next_activeFstop;
			activeInvert <= next_activeInvert;
		end
	end

	// ----------------------------------------
	// Terminal conditioning and function mapping
	// ----------------------------------------
	// Inversion first, then the two selectors read the conditioned terminals
	always_comb begin
		for (int i = 0; i < TERM_COUNT; i++) begin
			invMask[i] = 1'b0;
		end
		for (int i = 0; i < INV_TERM_COUNT; i++) begin
			invMask[i] = (activeInvert[i*DIGIT_W +: DIGIT_W] == DIGIT_INVERT);
		end
		next_termCond   = termIn ^ invMask;
		next_pulseMult  = pulseBus.level;
		next_forcedStop = fstopBus.level;
	end

	// Switch digit sits one place up, above a reserved digit
	assign pulseBus.digit = activePulse[PULSE_DIGIT_LSB +: DIGIT_W];
	assign pulseBus.term  = termCond;
	assign fstopBus.digit = activeFstop[FSTOP_DIGIT_LSB +: DIGIT_W];
	assign fstopBus.term  = termCond;

	ifm_func_select pulseSelect (.bus(pulseBus));
	ifm_func_select fstopSelect (.bus(fstopBus));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			termCond        <= 8'h00;
			pulseMultSwitch <= 1'b0;
			forcedStopInput <= 1'b0;
		end else begin
			termCond        <= next_termCond;
			pulseMultSwitch <= next_pulseMult;
			forcedStopInput <= next_forcedStop;
		end
	end

	// ----------------------------------------
	// Bus read path
	// ----------------------------------------
	// One read at a time, data one cycle after the address is taken
	always_comb begin
		next_rValid = s_axi_rvalid;
		next_rData  = s_axi_rdata;
		next_rResp  = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rValid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rValid = 1'b1;
			next_rResp  = RESP_OKAY;
			next_rData  = 32'h00000000;
			case (s_axi_araddr)
				ADDR_PULSE_SEL:  next_rData[15:0] = pulseSel;
				ADDR_FSTOP_SEL:  next_rData[15:0] = fstopSel;
				ADDR_INVERT_LOW: next_rData[15:0] = invertLow;
				ADDR_CONTROL:    next_rData = 32'h00000000;
				ADDR_STATUS: begin
					next_rData[STAT_PULSE_BIT] = pulseMultSwitch;
					next_rData[STAT_FSTOP_BIT] = forcedStopInput;
					next_rData[STAT_TERM_LSB +: TERM_COUNT] = termCond;
				end
				ADDR_ACT_PULSE:  next_rData[15:0] = activePulse;
				ADDR_ACT_FSTOP:  next_rData[15:0] = activeFstop;
				ADDR_ACT_INVERT: next_rData[15:0] = activeInvert;
				default:         next_rResp = RESP_SLVERR;
			endcase
		end
		next_arReady = !next_rValid;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_rvalid  <= next_rValid;
			s_axi_rdata   <= next_rData;
			s_axi_rresp   <= next_rResp;
			s_axi_arready <= next_arReady;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [3:0] pulseDigit;
	logic [3:0] fstopDigit;
	logic       pulsePick;
	logic       fstopPick;
	assign pulseDigit = activePulse[PULSE_DIGIT_LSB +: DIGIT_W];
	assign fstopDigit = activeFstop[FSTOP_DIGIT_LSB +: DIGIT_W];
	assign pulsePick  = termCond[pulseDigit[2:0]];
	assign fstopPick  = termCond[fstopDigit[2:0]];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence pulseTermSel;
		pulseDigit <= DIGIT_TERM_MAX;
	endsequence

	sequence restartSeen;
		applyPulse ##1 1'b1;
	endsequence

	pulse_follow_a: assert property (pulseTermSel |=> pulseMultSwitch == $past(pulsePick))
		else $error("switch does not follow its terminal");
	pulse_fixed_a: assert property (pulseDigit == DIGIT_OFF |=> !pulseMultSwitch)
		else $error("switch not held off");
	pulse_on_a: assert property (pulseDigit == DIGIT_ON |=> pulseMultSwitch)
		else $error("switch not held on");
	fstop_follow_a: assert property (fstopDigit <= DIGIT_TERM_MAX
		|=> forcedStopInput == $past(fstopPick))
		else $error("forced stop does not follow its terminal");
	fstop_fixed_a: assert property ((fstopDigit == DIGIT_OFF |=> !forcedStopInput)
		and (fstopDigit == DIGIT_ON |=> forcedStopInput))
		else $error("forced stop not held at fixed level");
	invert_path_a: assert property (1'b1 |=> termCond[3:0] == ($past(termIn[3:0])
		^ $past(invMask[3:0])))
		else $error("terminal inversion wrong");
	settings_hold_a: assert property (!applyPulse |=> $stable(activePulse)
		&& $stable(activeFstop) && $stable(activeInvert))
		else $error("active settings changed without restart");
	restart_load_a: assert property (restartSeen |-> activePulse == $past(pulseSel)
		&& activeFstop == $past(fstopSel))
		else $error("restart did not load settings");
	write_resp_a: assert property (doWrite |=> s_axi_bvalid ##0 !awHeld && !wHeld)
		else $error("write not answered");

endmodule

// >>> rtl/ifm_pkg.sv
package ifm_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0]  ADDR_PULSE_SEL   = 8'h00;
	localparam logic [7:0]  ADDR_FSTOP_SEL   = 8'h04;
	localparam logic [7:0]  ADDR_INVERT_LOW  = 8'h08;
	localparam logic [7:0]  ADDR_CONTROL     = 8'h0C;
	localparam logic [7:0]  ADDR_STATUS      = 8'h10;
	localparam logic [7:0]  ADDR_ACT_PULSE   = 8'h14;
	localparam logic [7:0]  ADDR_ACT_FSTOP   = 8'h18;
	localparam logic [7:0]  ADDR_ACT_INVERT  = 8'h1C;

	// ----------------------------------------
	// Reset values of the setting words
	// ----------------------------------------
	localparam logic [15:0] RST_PULSE_SEL    = 16'h0000;
	localparam logic [15:0] RST_FSTOP_SEL    = 16'h8888;
	localparam logic [15:0] RST_INVERT_LOW   = 16'h0000;

	// ----------------------------------------
	// Field layout and digit codes
	// ----------------------------------------
	localparam int          CTRL_RESTART_BIT = 0;
	localparam int          STAT_PULSE_BIT   = 0;
	localparam int          STAT_FSTOP_BIT   = 1;
	localparam int          STAT_TERM_LSB    = 8;
	localparam int          TERM_COUNT       = 8;
	localparam int          INV_TERM_COUNT   = 4;
	localparam int          DIGIT_W          = 4;
	localparam int          PULSE_DIGIT_LSB  = 4;
	localparam int          FSTOP_DIGIT_LSB  = 0;
	localparam logic [3:0]  DIGIT_TERM_MAX   = 4'h7;
	localparam logic [3:0]  DIGIT_OFF        = 4'h8;
	localparam logic [3:0]  DIGIT_ON         = 4'h9;
	localparam logic [3:0]  DIGIT_INVERT     = 4'h1;

	// ----------------------------------------
	// Bus answers
	// ----------------------------------------
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

// >>> rtl/ifm_sel_if.sv
`timescale 1ns/10ps
// Carries one selection digit and the terminal levels to a selector
interface ifm_sel_if;
	logic [3:0] digit;
	logic [7:0] term;
	logic       level;

	modport src (output digit, output term, input level);
	modport sel (input digit, input term, output level);
endinterface

// >>> rtl/ifm_func_select.sv
`timescale 1ns/10ps
// Picks one terminal, or a fixed level, by a selection digit
module ifm_func_select
	import ifm_pkg::*;
(
	ifm_sel_if.sel bus
);

	// ----------------------------------------
	// Digit decode
	// ----------------------------------------
	// Digits 0..7 follow a terminal, 9 forces on, 8 and unused codes force off
	always_comb begin
		if (bus.digit <= DIGIT_TERM_MAX) begin
			bus.level = bus.term[bus.digit[2:0]];
		end else begin
			bus.level = (bus.digit == DIGIT_ON);
		end
	end

endmodule

// >>> test/ifm_host_model.sv
`timescale 1ns/10ps
// Host controller side: levels on the connector input terminals
module ifm_host_model (
	input  wire logic       clk,
	output logic [7:0]      termOut
);
	initial termOut = 8'h00;

	// ----------------------------------------
	// Level change just after a rising edge
	// ----------------------------------------
	task automatic drive(input logic [7:0] lv);
		@(posedge clk);
		termOut <= lv;
	endtask
endmodule

// >>> test/ifm_input_mapper_test.sv
`timescale 1ns/10ps
// Register and terminal routing tests for the input mapper
module ifm_input_mapper_test
	import ifm_pkg::*;
;
	logic        clk, arst_n, awValid, wValid, bReady, arValid, rReady;
	logic        awReady, wReady, bValid, arReady, rValid, pulse, fstop;
	logic [7:0]  awAddr, arAddr, term;
	logic [31:0] wData, rData;
	logic [3:0]  wStrb;
	logic [1:0]  bResp, rResp;
	int          bad_count, total_checks;

	ifm_host_model u_host (.clk(clk), .termOut(term));
	ifm_input_mapper u_dut (.clk(clk), .arst_n(arst_n), .termIn(term),
		.pulseMultSwitch(pulse), .forcedStopInput(fstop), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady));

	// ----------------------------------------
	// Clock, reset and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#500000;
		bad_count++;
		final_report();
	end

	// ----------------------------------------
	// Compare tasks and expectations
	// ----------------------------------------
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		check_word({31'h0, got}, {31'h0, exp});
	endtask
	function automatic logic [7:0] inv_mask(input logic [15:0] iv);
		logic [7:0] m;
		m = 8'h00;
		for (int i = 0; i < 4; i++) m[i] = (iv[4*i+:4] == 4'h1);
		return m;
	endfunction
	function automatic logic exp_level(input logic [3:0] dg, input logic [7:0] t,
		input logic [15:0] iv);
		logic [7:0] c;
		c = t ^ inv_mask(iv);
		if (dg <= 4'h7) return c[dg[2:0]];
		return dg == 4'h9;
	endfunction

	// ----------------------------------------
	// AXI4-Lite master tasks
	// ----------------------------------------
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, done;
		@(posedge clk);
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge clk);
			if (!aw && !w && bValid === 1'b1) begin
				done = 1'b1;
				bReady <= 1'b0;
				check_word({30'h0, bResp}, {30'h0, er});
			end
			if (aw && awReady === 1'b1) begin
				aw = 1'b0;
				awValid <= 1'b0;
			end
			if (w && wReady === 1'b1) begin
				w = 1'b0;
				wValid <= 1'b0;
			end
		end
	endtask
	task automatic rd_check(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar, done;
		@(posedge clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		ar = 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge clk);
			if (!ar && rValid === 1'b1) begin
				done = 1'b1;
				rReady <= 1'b0;
				check_word(rData, ed);
				check_word({30'h0, rResp}, {30'h0, er});
			end
			if (ar && arReady === 1'b1) begin
				ar = 1'b0;
				arValid <= 1'b0;
			end
		end
	endtask
	// Lets the two-edge input path and the restart load land
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		logic [15:0] iv;
		logic [7:0]  p;
		logic        ep, ef;
		arst_n = 1'b0;
		{awValid, wValid, bReady, arValid, rReady} = 5'h00;
		awAddr = 8'h00;
		arAddr = 8'h00;
		wData = 32'h0;
		wStrb = 4'h3;
		bad_count = 0;
		total_checks = 0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rd_check(ADDR_PULSE_SEL, 32'h0, RESP_OKAY);
		rd_check(ADDR_FSTOP_SEL, 32'h8888, RESP_OKAY);
		rd_check(ADDR_INVERT_LOW, 32'h0, RESP_OKAY);
		rd_check(ADDR_ACT_FSTOP, 32'h8888, RESP_OKAY);
		rd_check(ADDR_CONTROL, 32'h0, RESP_OKAY);
		rd_check(8'h20, 32'h0, RESP_SLVERR);
		axi_write(8'h20, 32'h5, RESP_SLVERR);
		axi_write(ADDR_STATUS, 32'h3, RESP_SLVERR);
		// Low byte lane only
		wStrb <= 4'h1;
		axi_write(ADDR_INVERT_LOW, 32'h1111, RESP_OKAY);
		rd_check(ADDR_INVERT_LOW, 32'h0011, RESP_OKAY);
		wStrb <= 4'h3;
		$display("test registers done");
		// New word without restart keeps the reset selection
		axi_write(ADDR_PULSE_SEL, 32'h90, RESP_OKAY);
		rd_check(ADDR_PULSE_SEL, 32'h90, RESP_OKAY);
		u_host.drive(8'h00);
		settle();
		check_bit(pulse, 1'b0);
		check_bit(fstop, 1'b0);
		rd_check(ADDR_ACT_PULSE, 32'h0, RESP_OKAY);
		$display("test latching done");
		// Every digit code, with and without inversion
		for (int k = 0; k < 2; k++) begin
			iv = (k == 0) ? 16'h0000 : 16'h1201;
			for (int d = 0; d < 16; d++) begin
				axi_write(ADDR_PULSE_SEL, {24'h0, 4'(d), 4'h0}, RESP_OKAY);
				axi_write(ADDR_FSTOP_SEL, {16'h0, 12'h888, 4'(15 - d)}, RESP_OKAY);
				axi_write(ADDR_INVERT_LOW, {16'h0, iv}, RESP_OKAY);
				axi_write(ADDR_CONTROL, 32'h1, RESP_OKAY);
				for (int j = 0; j < 2; j++) begin
					p = (j == 0) ? 8'hA5 : 8'h5A;
					u_host.drive(p);
					settle();
					ep = exp_level(4'(d), p, iv);
					ef = exp_level(4'(15 - d), p, iv);
					check_bit(pulse, ep);
					check_bit(fstop, ef);
					rd_check(ADDR_STATUS, {16'h0, p ^ inv_mask(iv), 6'h0, ef, ep},
						RESP_OKAY);
				end
			end
			$display("test digit sweep %0d done", k);
		end
		final_report();
	end
endmodule
